//--- common/sff_pkg.sv
// Constants and types of the serial flash front end
//--------------------------------------------------------------
//--------------------------------------------------------------
package sff_pkg;

  //------------------------------------------------------------
  // Timing
  //------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned T_PROG_US = 700;
  localparam int unsigned T_ERASE4_US = 70_000;
  localparam int unsigned T_ERASE32_US = 300_000;
  localparam int unsigned T_ERASE64_US = 600_000;
  localparam int unsigned T_CHIP_US = 1_000_000;
  localparam int unsigned CYC_PROG = T_PROG_US * CLK_MHZ;
  localparam int unsigned CYC_ERASE4 = T_ERASE4_US * CLK_MHZ;
  localparam int unsigned CYC_ERASE32 = T_ERASE32_US * CLK_MHZ;
  localparam int unsigned CYC_ERASE64 = T_ERASE64_US * CLK_MHZ;
  localparam int unsigned CYC_CHIP = T_CHIP_US * CLK_MHZ;

  //------------------------------------------------------------
  // Framing and address fields
  //------------------------------------------------------------
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] ADDR_LAST = 6'h17;
  localparam logic [5:0] DUMMY_LAST = 6'h07;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LANES_1 = 4'h1;
  localparam logic [3:0] LANES_2 = 4'h2;
  localparam logic [3:0] LANES_4 = 4'h4;
  localparam int BLK_LSB = 16;
  localparam int BLK_MSB = 20;
  localparam int SEC_LSB = 12;
  localparam int SEC_MSB = 13;
  localparam int PAGE_MSB = 7;

  //------------------------------------------------------------
  // Opcodes
  //------------------------------------------------------------
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FREAD = 8'h0b;
  localparam logic [7:0] OPC_DREAD = 8'h3b;
  localparam logic [7:0] OPC_QREAD = 8'h6b;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_QPROG = 8'h32;
  localparam logic [7:0] OPC_ERASE4 = 8'h20;
  localparam logic [7:0] OPC_ERASE32 = 8'h52;
  localparam logic [7:0] OPC_ERASE64 = 8'hd8;
  localparam logic [7:0] OPC_CHIP = 8'h60;
  localparam logic [7:0] OPC_ID = 8'h9f;
  localparam logic [7:0] OPC_SREAD = 8'h48;
  localparam logic [7:0] OPC_SPROG = 8'h42;
  localparam logic [7:0] OPC_SLOCK = 8'h4a;

  //------------------------------------------------------------
  // Types
  //------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_ADDR = 3'b010,
    ST_DUMMY = 3'b011, ST_DIN = 3'b100, ST_DOUT = 3'b101,
    ST_SKIP = 3'b110
  } sff_state_t;

  typedef enum logic [3:0] {
    C_NONE = 4'h0, C_READ = 4'h1, C_FREAD = 4'h2, C_DREAD = 4'h3,
    C_QREAD = 4'h4, C_PROG = 4'h5, C_QPROG = 4'h6, C_ERASE4 = 4'h7,
    C_ERASE32 = 4'h8, C_ERASE64 = 4'h9, C_CHIP = 4'ha, C_ID = 4'hb,
    C_SREAD = 4'hc, C_SPROG = 4'hd, C_SLOCK = 4'he
  } sff_cls_t;

  typedef struct packed {
    sff_cls_t op;
    logic [23:0] addr;
    logic [7:0] data;
  } sff_mreq_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [3:0] io;
  } sff_pins_t;

  // Opcode to command class
  function automatic sff_cls_t classify(input logic [7:0] opc);
    case (opc)
      OPC_READ: classify = C_READ;
      OPC_FREAD: classify = C_FREAD;
      OPC_DREAD: classify = C_DREAD;
      OPC_QREAD: classify = C_QREAD;
      OPC_PROG: classify = C_PROG;
      OPC_QPROG: classify = C_QPROG;
      OPC_ERASE4: classify = C_ERASE4;
      OPC_ERASE32: classify = C_ERASE32;
      OPC_ERASE64: classify = C_ERASE64;
      OPC_CHIP: classify = C_CHIP;
      OPC_ID: classify = C_ID;
      OPC_SREAD: classify = C_SREAD;
      OPC_SPROG: classify = C_SPROG;
      OPC_SLOCK: classify = C_SLOCK;
      default: classify = C_NONE;
    endcase
  endfunction

endpackage

//--- hdl/sff_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sff_sync #(
  parameter int W = 1
)(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= '1;
      q_o <= '1;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

//--- hdl/sff_busy_timer.sv
// Self-timed program and erase busy counter
`timescale 1ns/100ps
`default_nettype none
module sff_busy_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic start_i,
  input wire logic [31:0] load_i,
  // Status
  output logic busy_o
);
  logic [31:0] count;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else if (start_i && !busy_o) begin
      count <= load_i;
    end else if (busy_o) begin
      count <= count - 32'h1;
    end
  end

  assign busy_o = (count != '0);
endmodule
`default_nettype wire

//--- hdl/sff_front_end.sv
// Serial flash SPI front end, device side
`timescale 1ns/100ps
`default_nettype none
module sff_front_end
  import sff_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a,    // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'ha5c3, // Arbitrary value
  parameter int unsigned PROG_CYC = CYC_PROG,
  parameter int unsigned ERASE4_CYC = CYC_ERASE4,
  parameter int unsigned ERASE32_CYC = CYC_ERASE32,
  parameter int unsigned ERASE64_CYC = CYC_ERASE64,
  parameter int unsigned CHIP_CYC = CYC_CHIP
)(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Block protection map
  input wire logic [31:0] prot_blocks_i,
  // Array side
  output sff_mreq_t mreq_o,
  output logic mreq_valid_o,
  input wire logic [7:0] mrdata_i,
  // Status
  output logic busy_o,
  output logic standby_o,
  output logic [2:0] sec_lock_o
);

  //------------------------------------------------------------
  // Functions
  //------------------------------------------------------------
  function automatic logic [3:0] place(input logic [7:0] b,
                                       input logic [3:0] n);
    case (n)
      LANES_4: place = b[7:4];
      LANES_2: place = {2'b00, b[7:6]};
      default: place = {2'b00, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input logic [3:0] n);
    case (n)
      LANES_4: lane_mask = 4'hf;
      LANES_2: lane_mask = 4'h3;
      default: lane_mask = 4'h2;
    endcase
  endfunction

  function automatic logic [31:0] cycles_of(input sff_cls_t c);
    case (c)
      C_ERASE4: cycles_of = ERASE4_CYC;
      C_ERASE32: cycles_of = ERASE32_CYC;
      C_ERASE64: cycles_of = ERASE64_CYC;
      C_CHIP: cycles_of = CHIP_CYC;
      default: cycles_of = PROG_CYC;
    endcase
  endfunction

  //------------------------------------------------------------
  // Declarations
  //------------------------------------------------------------
  sff_pins_t pins;
  sff_state_t state;
  sff_cls_t cls;
  logic cs_d, sck_d, hold_q, selected;
  logic cs_fall, cs_rise, sck_rise, sck_fall, quad_phase;
  logic [5:0] cnt;
  logic [7:0] sh_in, next_in, sh_out, nbyte;
  logic [23:0] addr, addr_nx;
  logic [3:0] lanes, obits, out_q, sec_lock;
  logic wp_cap, refused, got_data, cmd_done, lock_now;
  logic primed, drv, fetch, rd_pend, commit, start, byte_done;

  //------------------------------------------------------------
  // Pin sampling and edges
  //------------------------------------------------------------
  sff_sync #(
    .W(6)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .d_i({cs_n_i, sck_i, io_i}),
    .q_o(pins)
  );

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_d <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      cs_d <= pins.cs_n;
      sck_d <= pins.sck;
    end
  end

  assign selected = !pins.cs_n;
  assign cs_fall = cs_d && !pins.cs_n;
  assign cs_rise = !cs_d && pins.cs_n;
  assign quad_phase = (lanes == LANES_4) &&
                      (state == ST_DIN || state == ST_DOUT ||
                       state == ST_DUMMY);
  assign sck_rise = selected && !hold_q && !sck_d && pins.sck;
  assign sck_fall = selected && !hold_q && sck_d && !pins.sck;

  //------------------------------------------------------------
  // Pause
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_q <= 1'b0;
    end else if (!selected || pins.io[3] || quad_phase) begin
      hold_q <= 1'b0;
    end else if (!pins.sck) begin
      hold_q <= 1'b1;
    end
  end

  //------------------------------------------------------------
  // Input shifting and protection check
  //------------------------------------------------------------
  always_comb begin
    addr_nx = {addr[22:0], pins.io[0]};
    case (lanes)
      LANES_4: next_in = {sh_in[3:0], pins.io};
      default: next_in = {sh_in[6:0], pins.io[0]};
    endcase
    byte_done = (cnt[3:0] + lanes) == BYTE_BITS;
    case (cls)
      C_SPROG: lock_now = sec_lock[addr_nx[SEC_MSB:SEC_LSB]];
      C_SLOCK: lock_now = (addr_nx[SEC_MSB:SEC_LSB] == 2'b00);
      C_PROG, C_QPROG, C_ERASE4, C_ERASE32, C_ERASE64:
        lock_now = !wp_cap &&
                   prot_blocks_i[addr_nx[BLK_MSB:BLK_LSB]];
      default: lock_now = 1'b0;
    endcase
  end

  //------------------------------------------------------------
  // Command sequencer
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      cls <= C_NONE;
      cnt <= '0;
      sh_in <= '0;
      addr <= '0;
      lanes <= LANES_1;
      wp_cap <= 1'b1;
      refused <= 1'b0;
      got_data <= 1'b0;
      cmd_done <= 1'b0;
    end else if (!selected) begin
      state <= ST_IDLE;
    end else if (cs_fall) begin
      state <= ST_CMD;
      cls <= C_NONE;
      cnt <= '0;
      addr <= '0;
      lanes <= LANES_1;
      wp_cap <= pins.io[2];
      refused <= 1'b0;
      got_data <= 1'b0;
      cmd_done <= 1'b0;
    end else if (sck_rise) begin
      cnt <= cnt + 6'h1;
      case (state)
        ST_CMD: begin
          sh_in <= next_in;
          if (cnt == OPC_LAST) begin
            cnt <= '0;
            cls <= classify(next_in);
            case (classify(next_in))
              C_NONE: state <= ST_SKIP;
              C_ID: state <= ST_DOUT;
              C_CHIP: begin
                state <= ST_SKIP;
                cmd_done <= 1'b1;
                refused <= busy_o ||
                           (!wp_cap && (|prot_blocks_i));
              end
              default: state <= ST_ADDR;
            endcase
          end
        end
        ST_ADDR: begin
          addr <= addr_nx;
          if (cnt == ADDR_LAST) begin
            cnt <= '0;
            refused <= busy_o || lock_now;
            case (cls)
              C_READ: state <= ST_DOUT;
              C_FREAD, C_SREAD: state <= ST_DUMMY;
              C_DREAD: begin
                state <= ST_DUMMY;
                lanes <= LANES_2;
              end
              C_QREAD: begin
                state <= ST_DUMMY;
                lanes <= LANES_4;
              end
              C_PROG, C_SPROG: state <= ST_DIN;
              C_QPROG: begin
                state <= ST_DIN;
                lanes <= LANES_4;
              end
              default: begin
                state <= ST_SKIP;
                cmd_done <= 1'b1;
              end
            endcase
          end
        end
        ST_DUMMY: begin
          if (cnt == DUMMY_LAST) begin
            cnt <= '0;
            state <= ST_DOUT;
          end
        end
        ST_DIN: begin
          sh_in <= next_in;
          cnt <= {2'b00, cnt[3:0] + lanes};
          if (byte_done) begin
            cnt <= '0;
            got_data <= 1'b1;
            cmd_done <= 1'b1;
            addr[PAGE_MSB:0] <= addr[PAGE_MSB:0] + 8'h1;
          end
        end
        default: cnt <= '0;
      endcase
    end else if (fetch) begin
      addr <= addr + 24'h1;
    end
  end

  //------------------------------------------------------------
  // Output shifting
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      primed <= 1'b0;
      drv <= 1'b0;
      fetch <= 1'b0;
      obits <= '0;
      sh_out <= '0;
      out_q <= '0;
    end else if (state != ST_DOUT) begin
      primed <= 1'b0;
      drv <= 1'b0;
      fetch <= 1'b0;
      obits <= '0;
    end else begin
      fetch <= 1'b0;
      if (!primed) begin
        primed <= 1'b1;
        fetch <= 1'b1;
      end else if (sck_fall) begin
        drv <= 1'b1;
        if (obits == '0) begin
          out_q <= place(nbyte, lanes);
          sh_out <= nbyte << lanes;
          obits <= BYTE_BITS - lanes;
          fetch <= 1'b1;
        end else begin
          out_q <= place(sh_out, lanes);
          sh_out <= sh_out << lanes;
          obits <= obits - lanes;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nbyte <= '0;
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= fetch && (cls != C_ID);
      if (fetch && cls == C_ID) begin
        case (addr[1:0])
          2'h0: nbyte <= MFR_ID;
          2'h1: nbyte <= DEV_ID[15:8];
          2'h2: nbyte <= DEV_ID[7:0];
          default: nbyte <= '0;
        endcase
      end else if (rd_pend) begin
        nbyte <= mrdata_i;
      end
    end
  end

  assign io_o = out_q;
  assign io_oe_o = (state == ST_DOUT && drv && !hold_q) ?
                   lane_mask(lanes) : 4'h0;

  //------------------------------------------------------------
  // Array requests
  //------------------------------------------------------------
  assign commit = cs_rise && cmd_done && !refused;
  assign start = commit && (cls != C_SLOCK);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mreq_o <= '0;
      mreq_valid_o <= 1'b0;
    end else begin
      mreq_valid_o <= 1'b0;
      if (start && (cls == C_ERASE4 || cls == C_ERASE32 ||
                    cls == C_ERASE64 || cls == C_CHIP)) begin
        mreq_o <= '{op: cls, addr: addr, data: 8'h00};
        mreq_valid_o <= 1'b1;
      end else if (sck_rise && state == ST_DIN && byte_done &&
                   !refused) begin
        mreq_o <= '{op: cls, addr: addr, data: next_in};
        mreq_valid_o <= 1'b1;
      end else if (fetch && cls != C_ID) begin
        mreq_o <= '{op: cls, addr: addr, data: 8'h00};
        mreq_valid_o <= 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // Security locks and busy
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sec_lock <= 4'h1;
    end else if (commit && cls == C_SLOCK) begin
      sec_lock[addr[SEC_MSB:SEC_LSB]] <= 1'b1;
    end
  end

  sff_busy_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(start),
    .load_i(cycles_of(cls)),
    .busy_o(busy_o)
  );

  assign sec_lock_o = sec_lock[3:1];
  assign standby_o = pins.cs_n && !busy_o;

endmodule
`default_nettype wire

//--- tb/sff_sva.sv
// Port assertions for the serial flash front end
`timescale 1ns/100ps
`default_nettype none
module sff_chk
  import sff_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o,
  // Status
  input wire logic mreq_valid_o,
  input wire logic busy_o,
  input wire logic standby_o,
  input wire logic [2:0] sec_lock_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  sequence s_desel;
    cs_n_i [*6];
  endsequence
  sequence s_paused;
    (!cs_n_i && !io_i[3] && !sck_i) [*7];
  endsequence
  oe_desel_a: assert property (s_desel |-> io_oe_o == 4'h0)
    else $error("output driven while deselected");
  desel_req_a: assert property (cs_n_i [*8] |-> !mreq_valid_o)
    else $error("request while deselected");
  idle_stby_a:
    assert property ((cs_n_i && !busy_o) [*5] |-> standby_o)
    else $error("no standby while idle");
  sel_stby_a: assert property (!cs_n_i [*5] |-> !standby_o)
    else $error("standby while selected");
  busy_stby_a: assert property (busy_o |-> !standby_o)
    else $error("standby while busy");
  busy_start_a: assert property ($rose(busy_o) |-> cs_n_i)
    else $error("busy started inside a frame");
  lane_set_a:
    assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("bad output lane set");
  pause_float_a:
    assert property (s_paused |-> io_oe_o inside {4'h0, 4'hf})
    else $error("output driven while paused");
  out_edge_a:
    assert property ($changed(io_o) && io_oe_o != 4'h0
      |-> !($past(sck_i, 2) && $past(sck_i, 3)))
    else $error("output changed away from clock fall");
  lock_keep_a:
    assert property (($past(sec_lock_o) & ~sec_lock_o) == 3'h0)
    else $error("security lock cleared");
  lock_frame_a: assert property ($changed(sec_lock_o) |-> cs_n_i)
    else $error("lock changed inside a frame");
endmodule
`default_nettype wire

//--- tb/sff_host.sv
// Behavioural SPI host for the serial flash front end
`timescale 1ns/100ps
`default_nettype none
module sff_host (
  // Clock
  input wire logic sys_clk_i,
  // Pins
  input wire logic [3:0] io,
  output logic cs_n,
  output logic sck,
  output logic [3:0] drv,
  output logic [3:0] drv_oe
);
  logic m3 = 1'b0;
  logic wp = 1'b1;
  logic hold = 1'b1;
  logic dat = 1'b0;
  logic si_oe = 1'b0;
  logic rel = 1'b0;
  assign drv = {hold, wp, 1'b0, dat};
  assign drv_oe = rel ? 4'h0 : {3'b110, si_oe};
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge sys_clk_i);
  endtask
  task automatic start();
    sck = m3;
    half();
    cs_n = 1'b0;
    half();
  endtask
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      dat = b[i];
      si_oe = 1'b1;
      half();
      sck = 1'b1;
      half();
    end
  endtask
  task automatic get(input int n, output logic [7:0] b);
    si_oe = 1'b0;
    rel = (n == 4);
    for (int i = 0; i < 8 / n; i++) begin
      sck = 1'b0;
      half();
      sck = 1'b1;
      half();
      case (n)
        1: b = {b[6:0], io[1]};
        2: b = {b[5:0], io[1:0]};
        default: b = {b[3:0], io};
      endcase
    end
  endtask
  task automatic stop();
    sck = m3;
    half();
    cs_n = 1'b1;
    si_oe = 1'b0;
    rel = 1'b0;
    repeat (12) @(negedge sys_clk_i);
  endtask
  task automatic pause(input int n);
    sck = 1'b0;
    half();
    hold = 1'b0;
    repeat (n) @(negedge sys_clk_i);
    hold = 1'b1;
    half();
  endtask
  task automatic noise(input logic [31:0] v);
    si_oe = 1'b1;
    for (int i = 0; i < 32; i++) begin
      sck = v[i];
      dat = v[31 - i];
      half();
    end
    sck = m3;
    si_oe = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

//--- tb/sff_front_end_tb_top.sv
// Testbench top for the serial flash front end
`timescale 1ns/100ps
`default_nettype none
module sff_front_end_tb_top import sff_pkg::*;;
  localparam logic [7:0] MFR = 8'h3e; // Arbitrary value
  localparam logic [15:0] DEV = 16'h71d4; // Arbitrary value
  localparam int unsigned T = 50;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic flip = 1'b0;
  logic cs_n, sck, mreq_valid_o, busy_o, standby_o;
  logic [31:0] prot_blocks_i;
  logic [3:0] io_i, io_o, io_oe_o, drv, drv_oe;
  logic [7:0] mrdata_i;
  logic [2:0] sec_lock_o;
  sff_mreq_t mreq_o;
  sff_mreq_t exp_q[$];
  int num_errors = 0;
  int n_compared = 0;
  integer seed = 32'h8a42;
  logic [7:0] ropc [5] = '{OPC_READ, OPC_FREAD, OPC_DREAD, OPC_QREAD,
    OPC_SREAD};
  int rln [5] = '{1, 1, 2, 4, 1};
  logic [7:0] eopc [4] = '{OPC_ERASE4, OPC_ERASE32, OPC_ERASE64, OPC_CHIP};
  sff_cls_t ecls [4] = '{C_ERASE4, C_ERASE32, C_ERASE64, C_CHIP};
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) flip <= ~flip;
  for (genvar k = 0; k < 4; k++) begin : g_io
    assign io_i[k] = io_oe_o[k] ? io_o[k] : drv_oe[k] ? drv[k] :
      (k >= 2) ? 1'b1 : flip ^ (k == 1);
  end
  assign mrdata_i = mreq_o.addr[7:0] ^ 8'h3c;
  sff_front_end #(.MFR_ID(MFR), .DEV_ID(DEV), .PROG_CYC(T), .ERASE4_CYC(T),
    .ERASE32_CYC(T), .ERASE64_CYC(T), .CHIP_CYC(T)) dut (.sys_clk_i,
    .reset_n_i, .cs_n_i(cs_n), .sck_i(sck), .io_i, .io_o, .io_oe_o,
    .prot_blocks_i, .mreq_o, .mreq_valid_o, .mrdata_i, .busy_o,
    .standby_o, .sec_lock_o);
  sff_host host (.sys_clk_i, .io(io_i), .cs_n, .sck, .drv, .drv_oe);
  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_req(input sff_mreq_t e, g);
    chk("mreq op", e.op, g.op);
    if (e.op inside {C_ERASE4, C_ERASE32, C_ERASE64}) begin
      chk("erase addr", e.addr, g.addr);
    end
    if (e.op == C_PROG || e.op == C_SPROG) begin
      chk("mreq addr", e.addr, g.addr);
      chk("mreq data", e.data, g.data);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(negedge sys_clk_i) begin
    if (mreq_valid_o && mreq_o.op inside {C_PROG, C_QPROG, C_ERASE4,
        C_ERASE32, C_ERASE64, C_CHIP, C_SPROG}) begin
      if (exp_q.size() == 0) begin
        chk("mreq count", 32'h0, 32'h1);
      end else begin
        chk_req(exp_q.pop_front(), mreq_o);
      end
    end
  end
  //------------------------------------------------------------
  // Frames
  //------------------------------------------------------------
  task automatic settle(input bit ok);
    chk("busy", ok, busy_o);
    chk("standby", !ok, standby_o);
    for (int i = 0; i < 200 && busy_o; i++) @(negedge sys_clk_i);
    chk("standby", 1, standby_o);
  endtask
  task automatic hdr(input logic [7:0] opc, input logic [23:0] a);
    host.start();
    host.put(opc);
    host.put(a[23:16]);
    host.put(a[15:8]);
    host.put(a[7:0]);
  endtask
  task automatic rd(input int k, input logic [23:0] a);
    logic [7:0] b;
    hdr(ropc[k], a);
    if (k != 0) host.put(8'h00);
    for (int i = 0; i < 3; i++) begin
      host.get(rln[k], b);
      chk("read byte", ((a + i) & 8'hff) ^ 8'h3c, b);
    end
    host.stop();
  endtask
  task automatic wr(input sff_cls_t op, input logic [23:0] a, input int n,
      input bit ok);
    sff_mreq_t e;
    hdr(op == C_PROG ? OPC_PROG : OPC_SPROG, a);
    for (int i = 0; i < n; i++) begin
      e = '{op, {a[23:8], a[7:0] + 8'(i)}, 8'($random(seed))};
      if (ok) exp_q.push_back(e);
      host.put(e.data);
    end
    host.stop();
    settle(ok);
  endtask
  task automatic er(input int k, input logic [23:0] a, input bit ok);
    sff_mreq_t e;
    e = '{ecls[k], a, 8'h00};
    if (ok) exp_q.push_back(e);
    if (k == 3) begin
      host.start();
      host.put(eopc[k]);
    end else begin
      hdr(eopc[k], a);
    end
    host.stop();
    settle(ok);
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    num_errors++;
    complete_run();
  end
  initial begin
    logic [7:0] b;
    logic [31:0] idw;
    idw = {MFR, DEV, 8'h00};
    prot_blocks_i = $random(seed);
    prot_blocks_i[5] = 1'b1;
    prot_blocks_i[9] = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk("standby idle", 1, standby_o);
    host.start();
    host.put(OPC_ID);
    for (int i = 0; i < 4; i++) begin
      host.get(1, b);
      chk("id byte", idw[31 - 8 * i -: 8], b);
      if (i == 1) begin
        fork
          host.pause(16);
          begin
            repeat (12) @(negedge sys_clk_i);
            chk("paused oe", 4'h0, io_oe_o);
          end
        join
      end
    end
    host.stop();
    for (int k = 0; k < 5; k++) begin
      host.m3 = k[0];
      rd(k, 24'($random(seed)));
    end
    host.m3 = 1'b0;
    wr(C_PROG, 24'($random(seed)), 256, 1);
    wr(C_PROG, 24'($random(seed)), 1, 1);
    for (int k = 0; k < 4; k++) er(k, 24'($random(seed)), 1);
    host.wp = 1'b0;
    er(2, 24'h050000, 0);
    er(0, 24'h053000, 0);
    wr(C_PROG, 24'h0500a0, 1, 0);
    er(2, 24'h090000, 1);
    host.wp = 1'b1;
    for (int p = 2; p < 4; p++) begin
      hdr(OPC_SLOCK, {10'h0, 2'(p), 12'h0});
      host.stop();
      chk("lock bits", p == 2 ? 3'b010 : 3'b110, sec_lock_o);
      for (int q = 0; q < 4; q++) begin
        wr(C_SPROG, {10'h0, 2'(q), 12'h0f0}, 2,
          q == 1 || (p == 2 && q == 3));
      end
    end
    host.noise($random(seed));
    chk("deselect busy", 0, busy_o);
    chk("queue left", 0, exp_q.size());
    complete_run();
  end
endmodule
bind sff_front_end sff_chk chk (.sys_clk_i, .reset_n_i, .cs_n_i, .sck_i,
  .io_i, .io_o, .io_oe_o, .mreq_valid_o, .busy_o, .standby_o, .sec_lock_o);
`default_nettype wire
